// ---- logic/typec_port_params.svh ----
// constants shared by the source port control logic: offsets, field positions, codes, timing.
// assumes it is included by its bare name by every design file that needs it.
// Operation
// - flag high load current above 1.95 A
// - pull attach indicator low while sink attached
// - sample enable only after standby supply good
// - enable high starts operation; never left floating
// - after start-up watch both CC lines
// - switch bus power on only after deglitch
// - apply VCONN to unused CC showing Ra
// - remove bus power at once on detach
// - advertise current level from two select inputs
// - enable low: switches off, outputs released, monitor off
`ifndef TYPEC_PORT_PARAMS_SVH
`define TYPEC_PORT_PARAMS_SVH

`define CLK_MHZ          200
`define DEBOUNCE_US      150
`define DEBOUNCE_CYCLES  (`DEBOUNCE_US * `CLK_MHZ)
`define DEB_CNT_W        24

// synchroniser lanes
`define SYNC_W           9
`define SY_AUX           0
`define SY_EN            1
`define SY_CC1_RD        2
`define SY_CC2_RD        3
`define SY_CC1_RA        4
`define SY_CC2_RA        5
`define SY_LOAD          6
`define SY_SEL           7
`define SY_SEL_HI        8

// register map, byte addresses
`define ADDR_W           4
`define REG_CTRL         4'h0
`define REG_STATUS       4'h4
`define REG_INT_STATUS   4'h8
`define REG_INT_MASK     4'hc
`define CTRL_PORT_EN     0
`define CTRL_RESET       1'h1

// status fields
`define ST_AUX_OK        0
`define ST_ENABLED       1
`define ST_ATTACHED      2
`define ST_FLIPPED       3
`define ST_BUS_ON        4
`define ST_VCONN_ON      5
`define ST_HI_CURRENT    6
`define ST_ADV_LO        8

// interrupt events
`define INT_W            4
`define INT_ATTACH       0
`define INT_DETACH       1
`define INT_HI_CURRENT   2
`define INT_DISABLE      3
`define INT_RESET        4'h0

// advertised source current codes
`define ADV_OFF          2'h0
`define ADV_DEFAULT      2'h1
`define ADV_1A5          2'h2
`define ADV_3A0          2'h3

`endif

// ---- logic/typec_port_pkg.sv ----
// types of the source port control logic.
// assumes nothing beyond a SystemVerilog compiler.
package typec_port_pkg;
	typedef enum logic [2:0] {
		st_uvlo,
		st_disabled,
		st_unattached,
		st_debounce,
		st_attached
	} port_state_type;

	typedef logic [1:0] adv_level_type;
endpackage : typec_port_pkg

// ---- logic/deglitch_if.sv ----
// carrier between the port controller and its attach deglitch timer.
// assumes both ends sit on the same clock.
interface deglitch_if;
	logic arm;
	logic done;

	modport ctrl  (output arm, input done);
	modport timer (input arm, output done);
endinterface : deglitch_if

// ---- logic/pin_sync.sv ----
// two-flop synchronisers for every asynchronous pin of the port controller.
// assumes the inputs come from comparators or pins outside the ref_clk domain.
`include "typec_port_params.svh"

module pin_sync (
	// clock and reset
	input  logic                ref_clk,
	input  logic                rst_n,
	// pins
	input  logic [`SYNC_W-1:0]  async_in,
	output logic [`SYNC_W-1:0]  sync_out
);
	genvar g;
	generate
		for (g = 0; g < `SYNC_W; g++) begin : g_lane
			logic meta_r;
			logic sync_r;

			// first stage is read only by the second stage
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_r <= 1'b0;
					sync_r <= 1'b0;
				end else begin
					meta_r <= async_in[g];
					sync_r <= meta_r;
				end
			end

			assign sync_out[g] = sync_r;
		end
	endgenerate
endmodule : pin_sync

// ---- logic/attach_deglitch.sv ----
// attach deglitch timer: done rises once arm has stood for the full interval.
// assumes arm drops whenever the attach condition changes, which restarts the count.
`include "typec_port_params.svh"

module attach_deglitch #(
	parameter int unsigned deglitch_cycles = `DEBOUNCE_CYCLES
) (
	// clock and reset
	input  logic        ref_clk,
	input  logic        rst_n,
	// controller side
	deglitch_if.timer   dg
);
	localparam logic [`DEB_CNT_W-1:0] last_count = `DEB_CNT_W'(deglitch_cycles - 1);

	logic [`DEB_CNT_W-1:0] cnt_r;
	logic [`DEB_CNT_W-1:0] cnt_nxt;

	always_comb begin
		cnt_nxt = '0;
		if (dg.arm) begin
			cnt_nxt = (cnt_r == last_count) ? cnt_r : cnt_r + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign dg.done = dg.arm && (cnt_r == last_count);
endmodule : attach_deglitch

// ---- logic/typec_source_port_control.sv ----
// control logic of a Type-C source port: start-up, attach, bus power, VCONN,
// current advertisement, attach and high-current indicators, Avalon-MM registers.
// assumes analog comparators feed the cc and load inputs, all asynchronous to ref_clk.
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`include "typec_port_params.svh"

module typec_source_port_control #(
	parameter int unsigned deglitch_cycles = `DEBOUNCE_CYCLES
) (
	// clock and reset
	input  logic        ref_clk,
	input  logic        rst_n,
	// register bus
	input  logic [3:0]  avs_address,
	input  logic        avs_read,
	input  logic        avs_write,
	input  logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic        avs_waitrequest,
	output logic        irq,
	// supply and enable pins
	input  logic        aux_uvlo_ok,
	input  logic        en,
	// cc and load comparators
	input  logic        cc1_rd,
	input  logic        cc2_rd,
	input  logic        cc1_ra,
	input  logic        cc2_ra,
	input  logic        load_over_thresh,
	// advertisement select pins
	input  logic        adv_level_sel,
	input  logic        adv_level_upper_sel,
	// power switch and cc controls
	output logic        cc_monitor_on,
	output logic        rp_cc1_on,
	output logic        rp_cc2_on,
	output logic [1:0]  rp_level,
	output logic        bus_switch_on,
	output logic        vconn_cc1_on,
	output logic        vconn_cc2_on,
	// open-drain indicators
	output logic        sink_attached_n_o,
	output logic        sink_attached_n_oe,
	output logic        load_high_n_o,
	output logic        load_high_n_oe
);
	logic [`SYNC_W-1:0] pins_s;
	logic aux_s;
	logic en_s;
	logic cc1_rd_s;
	logic cc2_rd_s;
	logic cc1_ra_s;
	logic cc2_ra_s;
	logic load_s;
	logic sel_s;
	logic sel_hi_s;

	pin_sync u_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.async_in ({adv_level_upper_sel, adv_level_sel, load_over_thresh, cc2_ra, cc1_ra,
			cc2_rd, cc1_rd, en, aux_uvlo_ok}),
		.sync_out (pins_s)
	);

	assign aux_s    = pins_s[`SY_AUX];
	assign en_s     = pins_s[`SY_EN];
	assign cc1_rd_s = pins_s[`SY_CC1_RD];
	assign cc2_rd_s = pins_s[`SY_CC2_RD];
	assign cc1_ra_s = pins_s[`SY_CC1_RA];
	assign cc2_ra_s = pins_s[`SY_CC2_RA];
	assign load_s   = pins_s[`SY_LOAD];
	assign sel_s    = pins_s[`SY_SEL];
	assign sel_hi_s = pins_s[`SY_SEL_HI];

	deglitch_if dg ();

	attach_deglitch #(
		.deglitch_cycles (deglitch_cycles)
	) u_deglitch (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.dg      (dg)
	);

	// control, interrupt status and interrupt mask registers, written over the bus
	logic                      port_en_r;
	logic                      port_en_nxt;
	logic [`INT_W-1:0]         int_status_r;
	logic [`INT_W-1:0]         int_status_nxt;
	logic [`INT_W-1:0]         int_mask_r;
	logic [`INT_W-1:0]         int_mask_nxt;

	// port state
	typec_port_pkg::port_state_type state_r;
	typec_port_pkg::port_state_type state_nxt;
	logic flip_r;
	logic flip_nxt;
	logic sink_seen;
	logic active_rd;

	// both Rd at once is a debug accessory, not a sink, so it never powers the bus
	assign sink_seen = cc1_rd_s ^ cc2_rd_s;
	assign active_rd = flip_r ? cc2_rd_s : cc1_rd_s;
	assign dg.arm    = (state_r == typec_port_pkg::st_debounce);

	always_comb begin
		state_nxt = state_r;
		flip_nxt  = flip_r;
		unique case (state_r)
			typec_port_pkg::st_uvlo: begin
				if (aux_s) begin
					state_nxt = typec_port_pkg::st_disabled;
				end
			end
			typec_port_pkg::st_disabled: begin
				if (en_s && port_en_r) begin
					state_nxt = typec_port_pkg::st_unattached;
				end
			end
			typec_port_pkg::st_unattached: begin
				if (sink_seen) begin
					state_nxt = typec_port_pkg::st_debounce;
					flip_nxt  = cc2_rd_s;
				end
			end
			typec_port_pkg::st_debounce: begin
				// a change of orientation restarts the deglitch from scratch
				if (!sink_seen || (cc2_rd_s != flip_r)) begin
					state_nxt = typec_port_pkg::st_unattached;
				end else if (dg.done) begin
					state_nxt = typec_port_pkg::st_attached;
				end
			end
			typec_port_pkg::st_attached: begin
				if (!active_rd) begin
					state_nxt = typec_port_pkg::st_unattached;
				end
			end
			default: begin
				state_nxt = typec_port_pkg::st_uvlo;
			end
		endcase
		if (!aux_s) begin
			state_nxt = typec_port_pkg::st_uvlo;
		end else if ((!en_s || !port_en_r) && (state_r != typec_port_pkg::st_uvlo)) begin
			state_nxt = typec_port_pkg::st_disabled;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= typec_port_pkg::st_uvlo;
			flip_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			flip_r  <= flip_nxt;
		end
	end

	// outputs follow the next state, so detach drops power on the very next edge
	logic attached_nxt;
	logic monitor_nxt;
	logic bus_nxt;
	logic vconn1_nxt;
	logic vconn2_nxt;
	logic rp1_nxt;
	logic rp2_nxt;
	logic sink_oe_nxt;
	logic load_oe_nxt;
	typec_port_pkg::adv_level_type level_nxt;
	logic monitor_r;
	logic bus_r;
	logic vconn1_r;
	logic vconn2_r;
	logic rp1_r;
	logic rp2_r;
	logic sink_oe_r;
	logic load_oe_r;
	typec_port_pkg::adv_level_type level_r;

	always_comb begin
		attached_nxt = (state_nxt == typec_port_pkg::st_attached);
		monitor_nxt  = (state_nxt == typec_port_pkg::st_unattached) ||
			(state_nxt == typec_port_pkg::st_debounce) || attached_nxt;
		bus_nxt      = attached_nxt;
		vconn1_nxt   = attached_nxt && flip_nxt && cc1_ra_s;
		vconn2_nxt   = attached_nxt && !flip_nxt && cc2_ra_s;
		// once attached, Rp stays only on the line the sink uses
		rp1_nxt      = monitor_nxt && !(attached_nxt && flip_nxt);
		rp2_nxt      = monitor_nxt && !(attached_nxt && !flip_nxt);
		sink_oe_nxt  = attached_nxt;
		load_oe_nxt  = attached_nxt && load_s;
		if (!monitor_nxt) begin
			level_nxt = `ADV_OFF;
		end else if (!sel_s) begin
			level_nxt = `ADV_DEFAULT;
		end else if (!sel_hi_s) begin
			level_nxt = `ADV_1A5;
		end else begin
			level_nxt = `ADV_3A0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			monitor_r <= 1'b0;
			bus_r     <= 1'b0;
			vconn1_r  <= 1'b0;
			vconn2_r  <= 1'b0;
			rp1_r     <= 1'b0;
			rp2_r     <= 1'b0;
			sink_oe_r <= 1'b0;
			load_oe_r <= 1'b0;
			level_r   <= `ADV_OFF;
		end else begin
			monitor_r <= monitor_nxt;
			bus_r     <= bus_nxt;
			vconn1_r  <= vconn1_nxt;
			vconn2_r  <= vconn2_nxt;
			rp1_r     <= rp1_nxt;
			rp2_r     <= rp2_nxt;
			sink_oe_r <= sink_oe_nxt;
			load_oe_r <= load_oe_nxt;
			level_r   <= level_nxt;
		end
	end

	assign cc_monitor_on      = monitor_r;
	assign bus_switch_on      = bus_r;
	assign vconn_cc1_on       = vconn1_r;
	assign vconn_cc2_on       = vconn2_r;
	assign rp_cc1_on          = rp1_r;
	assign rp_cc2_on          = rp2_r;
	assign rp_level           = level_r;
	assign sink_attached_n_o  = 1'b0;
	assign sink_attached_n_oe = sink_oe_r;
	assign load_high_n_o      = 1'b0;
	assign load_high_n_oe     = load_oe_r;

	// bus slave: one wait cycle, then the answer; write lands on the released edge
	function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off);
		hit = (a == off);
	endfunction : hit

	logic              ack_r;
	logic              ack_nxt;
	logic [31:0]       rdata_r;
	logic [31:0]       rdata_nxt;
	logic              req;
	logic              wr_fire;
	logic [31:0]       status_word;
	logic [`INT_W-1:0] events;
	logic [`INT_W-1:0] clear;

	assign req             = avs_read || avs_write;
	assign wr_fire         = avs_write && ack_r;
	assign avs_waitrequest = req && !ack_r;
	assign avs_readdata    = rdata_r;

	always_comb begin
		status_word                  = '0;
		status_word[`ST_AUX_OK]      = aux_s;
		status_word[`ST_ENABLED]     = monitor_r;
		status_word[`ST_ATTACHED]    = (state_r == typec_port_pkg::st_attached);
		status_word[`ST_FLIPPED]     = flip_r;
		status_word[`ST_BUS_ON]      = bus_r;
		status_word[`ST_VCONN_ON]    = vconn1_r || vconn2_r;
		status_word[`ST_HI_CURRENT]  = load_oe_r;
		status_word[`ST_ADV_LO +: 2] = level_r;
	end

	always_comb begin
		ack_nxt   = req && !ack_r;
		rdata_nxt = rdata_r;
		if (avs_read && !ack_r) begin
			rdata_nxt = '0;
			if (hit(avs_address, `REG_CTRL)) begin
				rdata_nxt[`CTRL_PORT_EN] = port_en_r;
			end else if (hit(avs_address, `REG_STATUS)) begin
				rdata_nxt = status_word;
			end else if (hit(avs_address, `REG_INT_STATUS)) begin
				rdata_nxt[`INT_W-1:0] = int_status_r;
			end else if (hit(avs_address, `REG_INT_MASK)) begin
				rdata_nxt[`INT_W-1:0] = int_mask_r;
			end
		end
	end

	always_comb begin
		events                  = '0;
		events[`INT_ATTACH]     = attached_nxt && (state_r != typec_port_pkg::st_attached);
		events[`INT_DETACH]     = !attached_nxt && (state_r == typec_port_pkg::st_attached);
		events[`INT_HI_CURRENT] = load_oe_nxt && !load_oe_r;
		events[`INT_DISABLE]    = monitor_r && !monitor_nxt;
		clear = '0;
		if (wr_fire && hit(avs_address, `REG_INT_STATUS)) begin
			clear = avs_writedata[`INT_W-1:0];
		end
		// a new event in the clearing cycle survives the clear
		int_status_nxt = (int_status_r & ~clear) | events;
		int_mask_nxt   = int_mask_r;
		port_en_nxt    = port_en_r;
		if (wr_fire && hit(avs_address, `REG_INT_MASK)) begin
			int_mask_nxt = avs_writedata[`INT_W-1:0];
		end
		if (wr_fire && hit(avs_address, `REG_CTRL)) begin
			port_en_nxt = avs_writedata[`CTRL_PORT_EN];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_r        <= 1'b0;
			rdata_r      <= '0;
			int_status_r <= `INT_RESET;
			int_mask_r   <= `INT_RESET;
			port_en_r    <= `CTRL_RESET;
		end else begin
			ack_r        <= ack_nxt;
			rdata_r      <= rdata_nxt;
			int_status_r <= int_status_nxt;
			int_mask_r   <= int_mask_nxt;
			port_en_r    <= port_en_nxt;
		end
	end

	assign irq = |(int_status_r & int_mask_r);

	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	high_current_a: assert property (
		(state_nxt == typec_port_pkg::st_attached) && load_s |=> load_high_n_oe && !load_high_n_o)
		else $error("high-current flag not raised under heavy load");
	attach_ind_a: assert property (
		$rose(bus_switch_on) |-> sink_attached_n_oe && !sink_attached_n_o)
		else $error("attach indicator not pulled low with bus power");
	uvlo_wait_a: assert property (
		!aux_s |=> (state_r == typec_port_pkg::st_uvlo) ##1 !cc_monitor_on)
		else $error("port left lockout without standby supply");
	enable_start_a: assert property (
		(state_r == typec_port_pkg::st_disabled) && aux_s && en_s && port_en_r |=> cc_monitor_on)
		else $error("enable high did not start monitoring");
	monitor_on_a: assert property (
		(state_r == typec_port_pkg::st_unattached) |-> cc_monitor_on || $past(state_r) != state_r)
		else $error("cc monitoring off while waiting for a sink");
	deglitch_wait_a: assert property (
		$rose(bus_switch_on) |-> $past(state_r) == typec_port_pkg::st_debounce && $past(dg.done))
		else $error("bus power before the deglitch interval");
	vconn_apply_a: assert property (
		(state_r == typec_port_pkg::st_attached) && !flip_r && cc2_ra_s && active_rd && aux_s && en_s
		&& port_en_r |=> vconn_cc2_on && !vconn_cc1_on)
		else $error("VCONN not applied to the Ra line");
	detach_off_a: assert property (
		(state_r == typec_port_pkg::st_attached) && !active_rd |=> !bus_switch_on)
		else $error("bus power kept after detach");
	adv_level_a: assert property (
		monitor_nxt && sel_s && sel_hi_s |=> rp_level == `ADV_3A0)
		else $error("advertised level does not follow the selects");
	disable_all_a: assert property (
		!en_s |=> !bus_switch_on && !vconn_cc1_on && !vconn_cc2_on && !cc_monitor_on
		&& !sink_attached_n_oe && !load_high_n_oe)
		else $error("outputs still active while disabled");
	flag_drop_a: assert property (
		!load_s || !active_rd |=> !load_high_n_oe)
		else $error("high-current flag held without cause");
	vconn_idle_a: assert property (
		!cc1_ra_s && !cc2_ra_s |=> !vconn_cc1_on && !vconn_cc2_on)
		else $error("VCONN applied without Ra");
endmodule : typec_source_port_control

// ---- tb/sink_cable_model.sv ----
// behavioural sink and cable seen through the cc and load comparators.
// assumes the bench drives the plug commands just after a rising edge.
module sink_cable_model (
	// clock
	input  wire logic ref_clk,
	// commands from the bench
	input  wire logic plug,
	input  wire logic flip,
	input  wire logic ra,
	input  wire logic heavy,
	// from the port
	input  wire logic bus_on,
	// comparator outputs
	output logic      cc1_rd,
	output logic      cc2_rd,
	output logic      cc1_ra,
	output logic      cc2_ra,
	output logic      load_over
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		{cc1_rd, cc2_rd, cc1_ra, cc2_ra, load_over} = 5'h0;
	end

	// the cable puts Ra on the line the sink does not use; no load without bus power
	always @(posedge ref_clk) begin
		cc1_rd    <= plug & ~flip;
		cc2_rd    <= plug & flip;
		cc1_ra    <= plug & flip & ra;
		cc2_ra    <= plug & ~flip & ra;
		load_over <= plug & heavy & bus_on;
	end
endmodule : sink_cable_model

// ---- tb/test_typec_source_port_control.sv ----
// self-checking bench of the source port control: registers, start-up, attach, vconn, indicators.
// assumes the design is built with a short deglitch of 20 cycles.
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin num_errors++; $display("CHECK FAILED %0t %s", $time, m); end end

module test_typec_source_port_control;
	timeunit 1ns;
	timeprecision 1ps;

	logic        ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, d, seed;
	logic        aux, en, sel, hi, plug, flip, ra, heavy;
	logic        cc1_rd, cc2_rd, cc1_ra, cc2_ra, load_over;
	logic        mon, rp1, rp2, bus_on, vc1, vc2, att_o, att_oe, hc_o, hc_oe;
	logic [1:0]  rp_level;
	logic [2:0]  pick;
	int          num_errors, n_tests, cycles;
	wire         attach_pin = att_oe ? att_o : 1'b1;

	always #2.5 ref_clk = ~ref_clk;

	sink_cable_model i_sink (.ref_clk(ref_clk), .plug(plug), .flip(flip), .ra(ra), .heavy(heavy),
		.bus_on(bus_on), .cc1_rd(cc1_rd), .cc2_rd(cc2_rd), .cc1_ra(cc1_ra), .cc2_ra(cc2_ra),
		.load_over(load_over));

	typec_source_port_control #(.deglitch_cycles(20)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.irq(irq), .aux_uvlo_ok(aux), .en(en), .cc1_rd(cc1_rd), .cc2_rd(cc2_rd), .cc1_ra(cc1_ra),
		.cc2_ra(cc2_ra), .load_over_thresh(load_over), .adv_level_sel(sel), .adv_level_upper_sel(hi),
		.cc_monitor_on(mon), .rp_cc1_on(rp1), .rp_cc2_on(rp2), .rp_level(rp_level),
		.bus_switch_on(bus_on), .vconn_cc1_on(vc1), .vconn_cc2_on(vc2), .sink_attached_n_o(att_o),
		.sink_attached_n_oe(att_oe), .load_high_n_o(hc_o), .load_high_n_oe(hc_oe));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	function automatic logic [1:0] adv_exp(input logic s, input logic h);
		return !s ? 2'h1 : (h ? 2'h3 : 2'h2);
	endfunction : adv_exp

	task automatic summarize();
		if (num_errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize

	// a hang is cut short well past the longest expected run
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			summarize();
		end
	end

	task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge ref_clk);
		avs_address   <= a;
		avs_writedata <= wd;
		avs_read      <= ~wr;
		avs_write     <= wr;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus_xfer

	// waits for a level on the monitor (w=0) or the bus switch (w=1), bounded
	task automatic wait_lvl(input logic w, input logic v, input int lim);
		for (int k = 0; k < lim; k++) begin
			@(posedge ref_clk);
			if ((w ? bus_on : mon) === v) break;
		end
		@(posedge ref_clk);
	endtask : wait_lvl

	initial begin
		{ref_clk, rst_n, avs_read, avs_write, aux, sel, hi, plug, flip, ra, heavy} = '0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		en = 1'b1;
		seed = 32'h51ef;
		num_errors = 0;
		n_tests = 0;
		cycles = 0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		bus_xfer(0, 4'h0, 0, d); `CHK(d, 32'h1, "ctrl reset value")
		bus_xfer(0, 4'hc, 0, d); `CHK(d, 32'h0, "mask reset value")
		bus_xfer(1, 4'h2, 32'hffffffff, d);
		bus_xfer(0, 4'h2, 0, d); `CHK(d, 32'h0, "unmapped read")
		bus_xfer(0, 4'h4, 0, d); `CHK(d, 32'h0, "status in lockout")
		repeat (10) @(posedge ref_clk);
		`CHK(mon, 1'b0, "monitor before supply good")
		aux <= 1'b1;
		wait_lvl(0, 1, 12); `CHK(mon, 1'b1, "monitor after start-up")
		for (int i = 0; i < 4; i++) begin
			sel <= i[0];
			hi  <= i[1];
			repeat (5) @(posedge ref_clk);
			`CHK(rp_level, adv_exp(i[0], i[1]), "advertised level")
			`CHK({rp1, rp2}, 2'b11, "rp on both lines while unattached")
		end
		bus_xfer(1, 4'hc, 32'h1, d);
		bus_xfer(0, 4'hc, 0, d); `CHK(d, 32'h1, "mask readback")
		// short attaches, cut by orientation swaps and an unplug, never reach the bus switch
		plug <= 1'b1;
		for (int k = 0; k < 60; k++) begin
			@(posedge ref_clk);
			if (k == 8 || k == 24) flip <= ~flip;
			if (k == 40) plug <= 1'b0;
			`CHK(bus_on, 1'b0, "bus on after glitch")
		end
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			pick = (i == 0) ? 3'b110 : (i == 1) ? 3'b011 : seed[2:0];
			flip  <= pick[0];
			ra    <= pick[1];
			heavy <= pick[2];
			plug  <= 1'b1;
			repeat (15) @(posedge ref_clk);
			`CHK(bus_on, 1'b0, "bus on before deglitch")
			wait_lvl(1, 1, 40); `CHK(bus_on, 1'b1, "bus on after deglitch")
			repeat (4) @(posedge ref_clk);
			`CHK(attach_pin, 1'b0, "attach indicator low")
			`CHK(vc1, pick[0] & pick[1], "vconn on cc1")
			`CHK(vc2, ~pick[0] & pick[1], "vconn on cc2")
			`CHK({hc_oe, hc_o}, {pick[2], 1'b0}, "high current flag")
			`CHK({rp1, rp2}, {~pick[0], pick[0]}, "rp on the sink line")
			`CHK(irq, 1'b1, "attach interrupt")
			bus_xfer(1, 4'h8, 32'h1, d);
			@(posedge ref_clk);
			`CHK(irq, 1'b0, "interrupt cleared")
			bus_xfer(0, 4'h4, 0, d); `CHK(d[4:2], {1'b1, pick[0], 1'b1}, "status while attached")
			heavy <= 1'b0;
			repeat (6) @(posedge ref_clk);
			`CHK(hc_oe, 1'b0, "flag drops with load")
			heavy <= pick[2];
			repeat (6) @(posedge ref_clk);
			plug <= 1'b0;
			wait_lvl(1, 0, 5); `CHK(bus_on, 1'b0, "bus off on detach")
			`CHK(hc_oe, 1'b0, "flag off on detach")
			`CHK(attach_pin, 1'b1, "attach indicator released")
			`CHK(irq, 1'b0, "masked detach event")
			bus_xfer(0, 4'h8, 0, d); `CHK(d[1], 1'b1, "detach event")
			bus_xfer(1, 4'h8, 32'hf, d);
		end
		// disable by pin, then by register, each while fully attached
		for (int i = 0; i < 2; i++) begin
			{flip, ra, heavy, plug} <= 4'b0111;
			wait_lvl(1, 1, 40);
			if (i == 0) en <= 1'b0;
			else bus_xfer(1, 4'h0, 32'h0, d);
			repeat (6) @(posedge ref_clk);
			`CHK({mon, bus_on, vc1, vc2, att_oe, hc_oe}, 6'h0, "all off when disabled")
			en <= 1'b1;
			bus_xfer(1, 4'h0, 32'h1, d);
			plug <= 1'b0;
			repeat (6) @(posedge ref_clk);
		end
		// standby supply lost in mid-run sends the port back to lockout
		aux <= 1'b0;
		repeat (6) @(posedge ref_clk);
		`CHK({mon, rp1, rp2, rp_level}, 5'h0, "monitor off in lockout")
		summarize();
	end
endmodule : test_typec_source_port_control
